//--- fssp_pkg.sv
// constants, types and register map of the fault shutdown and status block
// Summary of operation
// (RULE1) sequenced style ramps the output down at the programmed ramp-down rate
// (RULE2) critical style switches both high-side and low-side switches off at once
// (RULE3) emergency style turns high-side off and low-side on in the same cycle
// (RULE4) over-temperature, under- and over-voltage each hold their own turn-off style
// (RULE5) 8-bit flags register at 0x16: bits 7,6 read-only, bits 5..0 fault flags
// (RULE6) the power manager reads the flags register when status monitoring is on
// (RULE7) a fault with propagation enabled pulls the shared fault line low
// (RULE8) a fault line pulled low by another starts our turn-off in the same style
// (RULE9) the style is encoded at the falling edge and decoded there by receivers; the decoder here decides when the line rises again or after PULSE_MAX cycles
// (RULE10) the power manager serves groups of 4, 8, 16 or 32 converters per line
// (RULE11) the fault line is driven only if the fault's spread enable bit is set
// (RULE12) a fault flag reads 0 while or after its fault occurs; 1 means no fault
// (RULE13) sequenced, critical and emergency use distinct low-pulse lengths on the line
package fssp_pkg;
   // ***************************************
   // register map
   // ***************************************
   localparam logic [7:0] ADDR_FLAGS = 8'h16;
   localparam logic [7:0] ADDR_SPREAD = 8'h17;
   localparam logic [7:0] ADDR_STYLE = 8'h18;
   localparam logic [7:0] ADDR_RATE = 8'h19;
   localparam logic [7:0] ADDR_CTRL = 8'h1A;
   localparam logic [7:0] ADDR_IRQ_ST = 8'h1B;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h1C;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h1D;
   localparam logic [7:0] ADDR_VSET = 8'h1E;
   // ***************************************
   // field positions and reset values
   // ***************************************
   localparam int FLG_HEATW = 7;
   localparam int FLG_PGOOD = 6;
   localparam int EVT_HEAT = 4;
   localparam int EVT_LOW = 2;
   localparam int EVT_HIGH = 1;
   localparam int CTRL_RESTART = 0;
   localparam logic [5:0] FLAGS_RST = 6'h3F;
   localparam logic [1:0] RO_RST = 2'h2;
   localparam logic [5:0] SPREAD_RST = 6'h3F;
   localparam logic [5:0] STYLE_RST = 6'h35;
   localparam logic [7:0] RATE_RST = 8'h0F;
   localparam logic [7:0] VSET_RST = 8'h80;
   localparam int IRQ_W = 3;
   localparam int IRQ_LOCAL = 0;
   localparam int IRQ_REMOTE = 1;
   localparam int IRQ_DONE = 2;
   // ***************************************
   // fault line pulse lengths in clock cycles
   // ***************************************
   localparam logic [4:0] PULSE_SEQ = 5'h04;
   localparam logic [4:0] PULSE_CRIT = 5'h08;
   localparam logic [4:0] PULSE_EMER = 5'h0C;
   localparam logic [4:0] THR_SEQ = 5'h06;
   localparam logic [4:0] THR_CRIT = 5'h0A;
   localparam logic [4:0] PULSE_MAX = 5'h10;
   localparam logic [4:0] GAP_LEN = 5'h04;
   // ***************************************
   // types
   // ***************************************
   typedef enum logic [1:0] {
      FSSP_NONE = 2'b00,
      FSSP_SEQ = 2'b01,
      FSSP_CRIT = 2'b10,
      FSSP_EMER = 2'b11
   } fssp_style_t;
   typedef enum logic [2:0] {
      FSSP_RUN = 3'b000,
      FSSP_RAMP = 3'b001,
      FSSP_CUT = 3'b010,
      FSSP_CLAMP = 3'b011,
      FSSP_DOWN = 3'b100
   } fssp_state_t;
   typedef enum logic [1:0] {
      FSSP_TX_IDLE = 2'b00,
      FSSP_TX_PULSE = 2'b01,
      FSSP_TX_GAP = 2'b10,
      FSSP_TX_HOLD = 2'b11
   } fssp_tx_t;
   // follow, heat, current, low, high, phase: same order as flag bits 5..0
   typedef struct packed {
      logic follow;
      logic heat;
      logic curr;
      logic low;
      logic high;
      logic phase;
   } fssp_evt_t;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } fssp_bus_t;
endpackage

//--- fssp_okline.sv
// fault line encoder and decoder
`timescale 1ns/10ps
module fssp_okline (
   input wire logic clk,
   input wire logic nrst,
   input wire logic tx_start,
   input wire fssp_pkg::fssp_style_t tx_style,
   input wire logic tx_hold,
   input wire logic line_in,
   output logic drive_q,
   output logic rx_pulse_q,
   output fssp_pkg::fssp_style_t rx_style_q
);
   fssp_pkg::fssp_tx_t tx_q;
   logic [4:0] tx_cnt_q;
   logic [4:0] tx_len;
   logic line_prev_q;
   logic [4:0] rx_cnt_q;
   logic rx_busy_q;

   always_comb begin
      unique case (tx_style)
         fssp_pkg::FSSP_SEQ: tx_len = fssp_pkg::PULSE_SEQ;
         fssp_pkg::FSSP_EMER: tx_len = fssp_pkg::PULSE_EMER;
         default: tx_len = fssp_pkg::PULSE_CRIT;
      endcase
   end

   // ***************************************
   // encoder: style pulse, short release, then held low
   // ***************************************
   always_ff @(posedge clk) begin
      if (!nrst) begin
         tx_q <= fssp_pkg::FSSP_TX_IDLE;
         tx_cnt_q <= 5'h00;
         drive_q <= 1'b0;
      end else begin
         unique case (tx_q)
            fssp_pkg::FSSP_TX_IDLE: begin
               if (tx_start) begin // RULE9
                  tx_q <= fssp_pkg::FSSP_TX_PULSE;
                  tx_cnt_q <= tx_len - 5'h01; // RULE13
                  drive_q <= 1'b1;
               end
            end
            fssp_pkg::FSSP_TX_PULSE: begin
               if (tx_cnt_q == 5'h00) begin
                  tx_q <= fssp_pkg::FSSP_TX_GAP;
                  tx_cnt_q <= fssp_pkg::GAP_LEN - 5'h01;
                  drive_q <= 1'b0;
               end else begin
                  tx_cnt_q <= tx_cnt_q - 5'h01;
               end
            end
            fssp_pkg::FSSP_TX_GAP: begin
               if (tx_cnt_q == 5'h00) begin
                  tx_q <= tx_hold ? fssp_pkg::FSSP_TX_HOLD : fssp_pkg::FSSP_TX_IDLE;
                  drive_q <= tx_hold;
               end else begin
                  tx_cnt_q <= tx_cnt_q - 5'h01;
               end
            end
            fssp_pkg::FSSP_TX_HOLD: begin
               if (!tx_hold) begin
                  tx_q <= fssp_pkg::FSSP_TX_IDLE;
                  drive_q <= 1'b0;
               end
            end
         endcase
      end
   end

   // ***************************************
   // decoder: length of the first low pulse names the style
   // ***************************************
   // a line stuck low past the longest pulse is taken as critical
   always_ff @(posedge clk) begin
      if (!nrst) begin
         line_prev_q <= 1'b1;
         rx_cnt_q <= 5'h00;
         rx_busy_q <= 1'b0;
         rx_pulse_q <= 1'b0;
         rx_style_q <= fssp_pkg::FSSP_NONE;
      end else begin
         line_prev_q <= line_in;
         rx_pulse_q <= 1'b0;
         if (line_prev_q && !line_in && !drive_q && tx_q == fssp_pkg::FSSP_TX_IDLE) begin
            rx_busy_q <= 1'b1; // RULE9
            rx_cnt_q <= 5'h01;
         end else if (rx_busy_q) begin
            if (line_in) begin
               rx_busy_q <= 1'b0;
               rx_pulse_q <= 1'b1;
               if (rx_cnt_q < fssp_pkg::THR_SEQ) begin // RULE13
                  rx_style_q <= fssp_pkg::FSSP_SEQ;
               end else if (rx_cnt_q < fssp_pkg::THR_CRIT) begin
                  rx_style_q <= fssp_pkg::FSSP_CRIT;
               end else begin
                  rx_style_q <= fssp_pkg::FSSP_EMER;
               end
            end else if (rx_cnt_q == fssp_pkg::PULSE_MAX) begin
               rx_busy_q <= 1'b0;
               rx_pulse_q <= 1'b1;
               rx_style_q <= fssp_pkg::FSSP_CRIT;
            end else begin
               rx_cnt_q <= rx_cnt_q + 5'h01;
            end
         end
      end
   end

   a_seq_pulse_len: assert property (@(posedge clk) disable iff (!nrst)
      tx_q == fssp_pkg::FSSP_TX_IDLE && tx_start && tx_style == fssp_pkg::FSSP_SEQ
      |=> drive_q [*4] ##1 !drive_q) // RULE13
      else $error("sequenced pulse is not four cycles");
   a_emer_decode: assert property (@(posedge clk) disable iff (!nrst)
      rx_busy_q && line_in && rx_cnt_q >= fssp_pkg::THR_CRIT
      |=> rx_pulse_q && rx_style_q == fssp_pkg::FSSP_EMER) // RULE9
      else $error("long pulse not decoded as emergency");
endmodule

//--- fssp_top.sv
// fault shutdown, status flags and fault line propagation of a load converter
//
// Our own choice: strobed register access.
`timescale 1ns/10ps
module fssp_top (
   input wire logic clk,
   input wire logic nrst,
   input wire fssp_pkg::fssp_bus_t bus,
   output logic [7:0] rdata_q,
   input wire fssp_pkg::fssp_evt_t evt,
   input wire logic heat_warn,
   input wire logic power_good,
   input wire logic ok_i,
   output logic ok_o,
   output logic ok_oe,
   output logic hs_en_q,
   output logic ls_en_q,
   output logic ls_force_q,
   output logic [7:0] vout_cmd_q,
   output logic irq_q
);
   localparam int IRQ_W_L = fssp_pkg::IRQ_W;
   logic [5:0] flags_q;
   logic [1:0] ro_q;
   logic [5:0] spread_q;
   logic [5:0] style_cfg_q;
   logic [7:0] rate_q;
   logic [7:0] vset_q;
   logic [IRQ_W_L-1:0] irq_st_q;
   logic [IRQ_W_L-1:0] irq_en_q;
   fssp_pkg::fssp_state_t state_q;
   fssp_pkg::fssp_style_t style_q;
   logic [7:0] rate_cnt_q;
   logic [5:0] evt_prev_q;
   logic [5:0] evt_v;
   logic [5:0] evt_rise;
   logic own_trig;
   fssp_pkg::fssp_style_t own_style;
   logic remote_trig;
   logic tx_start;
   logic tx_hold;
   logic drive;
   logic rx_pulse;
   fssp_pkg::fssp_style_t rx_style;
   logic restart;
   logic trig;
   fssp_pkg::fssp_style_t trig_style;
   logic [IRQ_W_L-1:0] irq_set;

   // style per event: three configurable, the rest always critical
   function automatic fssp_pkg::fssp_style_t style_of(input int idx, input logic [5:0] cfg);
      fssp_pkg::fssp_style_t s;
      s = fssp_pkg::FSSP_CRIT;
      if (idx == fssp_pkg::EVT_HEAT) s = fssp_pkg::fssp_style_t'(cfg[1:0]);
      if (idx == fssp_pkg::EVT_LOW) s = fssp_pkg::fssp_style_t'(cfg[3:2]);
      if (idx == fssp_pkg::EVT_HIGH) s = fssp_pkg::fssp_style_t'(cfg[5:4]);
      if (s == fssp_pkg::FSSP_NONE) s = fssp_pkg::FSSP_CRIT;
      return s;
   endfunction

   // the harsher of two styles; encodings grow with severity
   function automatic fssp_pkg::fssp_style_t harsher(input fssp_pkg::fssp_style_t a,
                                                      input fssp_pkg::fssp_style_t b);
      return (a > b) ? a : b;
   endfunction

   // ***************************************
   // event detection and style choice
   // ***************************************
   assign evt_v = evt;
   assign evt_rise = evt_v & ~evt_prev_q;

   always_comb begin
      own_style = fssp_pkg::FSSP_NONE;
      for (int i = 0; i < 6; i++) begin
         if (evt_rise[i]) begin
            own_style = harsher(own_style, style_of(i, style_cfg_q)); // RULE4
         end
      end
   end

   assign own_trig = |evt_rise;
   assign remote_trig = rx_pulse && !drive; // RULE8
   assign trig = own_trig || remote_trig;
   assign trig_style = own_trig ? own_style : rx_style;
   assign restart = bus.wr && bus.addr == fssp_pkg::ADDR_CTRL
                    && bus.wdata[fssp_pkg::CTRL_RESTART] && evt_v == 6'h00 && ok_i;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         evt_prev_q <= 6'h00;
      end else begin
         evt_prev_q <= evt_v;
      end
   end

   // ***************************************
   // fault line propagation
   // ***************************************
   assign tx_start = |(evt_rise & spread_q); // RULE7 RULE11
   assign tx_hold = state_q != fssp_pkg::FSSP_RUN;
   assign ok_o = 1'b0;
   assign ok_oe = drive;

   fssp_okline u_okline (
      .clk(clk),
      .nrst(nrst),
      .tx_start(tx_start),
      .tx_style(own_style),
      .tx_hold(tx_hold),
      .line_in(ok_i),
      .drive_q(drive),
      .rx_pulse_q(rx_pulse),
      .rx_style_q(rx_style)
   );

   // ***************************************
   // shutdown state machine
   // ***************************************
   // a sequenced ramp may still be cut short by a harsher style
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_q <= fssp_pkg::FSSP_RUN;
         style_q <= fssp_pkg::FSSP_NONE;
         hs_en_q <= 1'b1;
         ls_en_q <= 1'b1;
         ls_force_q <= 1'b0;
      end else if (trig && (state_q == fssp_pkg::FSSP_RUN
                   || (state_q == fssp_pkg::FSSP_RAMP && trig_style != fssp_pkg::FSSP_SEQ))) begin
         style_q <= trig_style; // RULE4 RULE8
         unique case (trig_style)
            fssp_pkg::FSSP_SEQ: begin
               state_q <= fssp_pkg::FSSP_RAMP; // RULE1
            end
            fssp_pkg::FSSP_EMER: begin
               state_q <= fssp_pkg::FSSP_CLAMP;
               hs_en_q <= 1'b0; // RULE3
               ls_en_q <= 1'b1;
               ls_force_q <= 1'b1;
            end
            default: begin
               state_q <= fssp_pkg::FSSP_CUT;
               hs_en_q <= 1'b0; // RULE2
               ls_en_q <= 1'b0;
               ls_force_q <= 1'b0;
            end
         endcase
      end else begin
         unique case (state_q)
            fssp_pkg::FSSP_RAMP: begin
               if (vout_cmd_q == 8'h00) begin
                  state_q <= fssp_pkg::FSSP_DOWN;
                  hs_en_q <= 1'b0;
                  ls_en_q <= 1'b0;
               end
            end
            fssp_pkg::FSSP_CUT, fssp_pkg::FSSP_CLAMP, fssp_pkg::FSSP_DOWN: begin
               if (restart) begin
                  state_q <= fssp_pkg::FSSP_RUN;
                  style_q <= fssp_pkg::FSSP_NONE;
                  hs_en_q <= 1'b1;
                  ls_en_q <= 1'b1;
                  ls_force_q <= 1'b0;
               end
            end
            fssp_pkg::FSSP_RUN: begin
               state_q <= fssp_pkg::FSSP_RUN;
            end
            default: begin
               state_q <= fssp_pkg::FSSP_CUT;
               hs_en_q <= 1'b0;
               ls_en_q <= 1'b0;
               ls_force_q <= 1'b0;
            end
         endcase
      end
   end

   // ***************************************
   // output ramp
   // ***************************************
   // one step every rate_q+1 cycles; rate 0 means one step per cycle
   always_ff @(posedge clk) begin
      if (!nrst) begin
         vout_cmd_q <= fssp_pkg::VSET_RST;
         rate_cnt_q <= 8'h00;
      end else if (state_q == fssp_pkg::FSSP_RUN) begin
         vout_cmd_q <= vset_q;
         rate_cnt_q <= 8'h00;
      end else if (state_q == fssp_pkg::FSSP_RAMP) begin
         if (rate_cnt_q >= rate_q) begin
            rate_cnt_q <= 8'h00;
            if (vout_cmd_q != 8'h00) begin
               vout_cmd_q <= vout_cmd_q - 8'h01; // RULE1
            end
         end else begin
            rate_cnt_q <= rate_cnt_q + 8'h01;
         end
      end else begin
         vout_cmd_q <= 8'h00;
      end
   end

   // ***************************************
   // protection flags
   // ***************************************
   // an active fault wins over a software write of 1
   always_ff @(posedge clk) begin
      if (!nrst) begin
         flags_q <= fssp_pkg::FLAGS_RST;
         ro_q <= fssp_pkg::RO_RST;
      end else begin
         ro_q <= {heat_warn, power_good}; // RULE5
         for (int i = 0; i < 6; i++) begin
            if (evt_v[i]) begin
               flags_q[i] <= 1'b0; // RULE12
            end else if (bus.wr && bus.addr == fssp_pkg::ADDR_FLAGS) begin
               flags_q[i] <= bus.wdata[i]; // RULE5
            end
         end
      end
   end

   // ***************************************
   // configuration registers
   // ***************************************
   always_ff @(posedge clk) begin
      if (!nrst) begin
         spread_q <= fssp_pkg::SPREAD_RST;
         style_cfg_q <= fssp_pkg::STYLE_RST;
         rate_q <= fssp_pkg::RATE_RST;
         vset_q <= fssp_pkg::VSET_RST;
         irq_en_q <= '0;
      end else if (bus.wr) begin
         unique case (bus.addr)
            fssp_pkg::ADDR_SPREAD: spread_q <= bus.wdata[5:0]; // RULE11
            fssp_pkg::ADDR_STYLE: style_cfg_q <= bus.wdata[5:0]; // RULE4
            fssp_pkg::ADDR_RATE: rate_q <= bus.wdata;
            fssp_pkg::ADDR_VSET: vset_q <= bus.wdata;
            fssp_pkg::ADDR_IRQ_EN: irq_en_q <= bus.wdata[IRQ_W_L-1:0];
            default: irq_en_q <= irq_en_q;
         endcase
      end
   end

   // ***************************************
   // interrupts
   // ***************************************
   always_comb begin
      irq_set = '0;
      irq_set[fssp_pkg::IRQ_LOCAL] = own_trig;
      irq_set[fssp_pkg::IRQ_REMOTE] = remote_trig;
      irq_set[fssp_pkg::IRQ_DONE] = state_q == fssp_pkg::FSSP_RAMP && vout_cmd_q == 8'h00;
   end

   // a new event in the clearing cycle stays set
   always_ff @(posedge clk) begin
      if (!nrst) begin
         irq_st_q <= '0;
         irq_q <= 1'b0;
      end else begin
         if (bus.wr && bus.addr == fssp_pkg::ADDR_IRQ_CLR) begin
            irq_st_q <= (irq_st_q & ~bus.wdata[IRQ_W_L-1:0]) | irq_set;
            irq_q <= |(((irq_st_q & ~bus.wdata[IRQ_W_L-1:0]) | irq_set) & irq_en_q);
         end else begin
            irq_st_q <= irq_st_q | irq_set;
            irq_q <= |((irq_st_q | irq_set) & irq_en_q);
         end
      end
   end

   // ***************************************
   // register read port
   // ***************************************
   // unmapped and write-only addresses read as zero
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rdata_q <= 8'h00;
      end else if (bus.rd) begin
         unique case (bus.addr)
            fssp_pkg::ADDR_FLAGS: rdata_q <= {ro_q, flags_q}; // RULE5 RULE6
            fssp_pkg::ADDR_SPREAD: rdata_q <= {2'h0, spread_q};
            fssp_pkg::ADDR_STYLE: rdata_q <= {2'h0, style_cfg_q};
            fssp_pkg::ADDR_RATE: rdata_q <= rate_q;
            fssp_pkg::ADDR_CTRL: rdata_q <= {3'h0, state_q, style_q};
            fssp_pkg::ADDR_IRQ_ST: rdata_q <= {5'h00, irq_st_q};
            fssp_pkg::ADDR_IRQ_EN: rdata_q <= {5'h00, irq_en_q};
            fssp_pkg::ADDR_VSET: rdata_q <= vset_q;
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   // ***************************************
   // assertions
   // ***************************************
   a_seq_enters_ramp: assert property (@(posedge clk) disable iff (!nrst)
      state_q == fssp_pkg::FSSP_RUN && own_trig && own_style == fssp_pkg::FSSP_SEQ
      |=> state_q == fssp_pkg::FSSP_RAMP && hs_en_q) // RULE1
      else $error("sequenced fault did not start a ramp");
   a_ramp_step: assert property (@(posedge clk) disable iff (!nrst)
      state_q == fssp_pkg::FSSP_RAMP && !trig && rate_cnt_q >= rate_q && vout_cmd_q != 8'h00
      |=> vout_cmd_q == $past(vout_cmd_q) - 8'h01) // RULE1
      else $error("ramp step missing");
   a_crit_both_off: assert property (@(posedge clk) disable iff (!nrst)
      state_q == fssp_pkg::FSSP_RUN && own_trig && own_style == fssp_pkg::FSSP_CRIT
      |=> !hs_en_q && !ls_en_q && !ls_force_q) // RULE2
      else $error("critical turn-off left a switch on");
   a_emer_clamp: assert property (@(posedge clk) disable iff (!nrst)
      state_q == fssp_pkg::FSSP_RUN && own_trig && own_style == fssp_pkg::FSSP_EMER
      |=> !hs_en_q && ls_force_q) // RULE3
      else $error("emergency turn-off did not clamp low side");
   a_style_kept: assert property (@(posedge clk) disable iff (!nrst)
      state_q == fssp_pkg::FSSP_RUN && own_trig |=> style_q == $past(own_style)) // RULE4
      else $error("turn-off style not taken from event");
   a_flag_cleared: assert property (@(posedge clk) disable iff (!nrst)
      evt_v[fssp_pkg::EVT_HIGH] |=> !flags_q[fssp_pkg::EVT_HIGH]) // RULE12
      else $error("fault flag not written as 0");
   a_ro_bits: assert property (@(posedge clk) disable iff (!nrst)
      bus.rd && bus.addr == fssp_pkg::ADDR_FLAGS
      |=> rdata_q[fssp_pkg::FLG_PGOOD] == $past(ro_q[0])) // RULE5
      else $error("power good bit misread");
   // the hold after the gap lowers the line again without a new start
   a_spread_gate: assert property (@(posedge clk) disable iff (!nrst)
      $rose(ok_oe) |-> $past(tx_start) || $past(ok_oe, 5)) // RULE11
      else $error("fault line driven without spread enable");
   a_remote_follow: assert property (@(posedge clk) disable iff (!nrst)
      state_q == fssp_pkg::FSSP_RUN && remote_trig && !own_trig
      |=> state_q != fssp_pkg::FSSP_RUN && style_q == $past(rx_style)) // RULE8
      else $error("remote fault not followed");
   a_propagate: assert property (@(posedge clk) disable iff (!nrst)
      tx_start && !ok_oe && state_q == fssp_pkg::FSSP_RUN |=> ok_oe) // RULE7
      else $error("enabled fault did not pull the line");

   c_seq_down: cover property (@(posedge clk) disable iff (!nrst)
      state_q == fssp_pkg::FSSP_RAMP ##1 state_q == fssp_pkg::FSSP_DOWN);
   c_remote: cover property (@(posedge clk) disable iff (!nrst) remote_trig);
   c_restart: cover property (@(posedge clk) disable iff (!nrst)
      state_q == fssp_pkg::FSSP_CLAMP ##1 state_q == fssp_pkg::FSSP_RUN);
endmodule

//--- fssp_pm_model.sv
// behavioural power manager and sibling converter on the shared fault line
`timescale 1ns/10ps
module fssp_pm_model #(
   parameter int GROUP = 4
) (
   input wire logic clk,
   input wire logic line,
   input wire logic send,
   input wire logic [4:0] send_len,
   output logic pull,
   output logic [4:0] rx_len
);
   logic [4:0] tx_q = 5'h00;
   logic [4:0] cnt_q = 5'h00;
   // ***************************************
   // sibling pulse: the length carries the style
   // ***************************************
   always @(posedge clk) begin
      if (send) begin
         tx_q <= send_len;
      end else if (tx_q != 5'h00) begin
         tx_q <= tx_q - 5'h01;
      end
   end
   assign pull = (tx_q != 5'h00);
   // ***************************************
   // receiver: length of each low stretch not of our own making
   // ***************************************
   always @(posedge clk) begin
      if (!line && !pull) begin
         cnt_q <= cnt_q + 5'h01;
      end else if (cnt_q != 5'h00) begin
         rx_len <= cnt_q;
         cnt_q <= 5'h00;
      end
   end
endmodule

//--- fault_shutdown_status_propagation_tb.sv
// self-checking bench of the fault shutdown and status block
`timescale 1ns/10ps
module fault_shutdown_status_propagation_tb;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   fssp_pkg::fssp_bus_t bus = '0;
   fssp_pkg::fssp_evt_t evt = '0;
   logic heat_warn = 1'b0;
   logic power_good = 1'b1;
   logic [7:0] rdata_q;
   logic ok_o;
   logic ok_oe;
   logic hs_en_q;
   logic ls_en_q;
   logic ls_force_q;
   logic irq_q;
   logic [7:0] vout_cmd_q;
   logic pull;
   logic send = 1'b0;
   logic [4:0] send_len = 5'h00;
   logic [4:0] rx_len;
   logic [31:0] seed = 32'h1884;
   int err_count = 0;
   int checked = 0;
   // open-drain line with pull-up
   wire logic ok_i = !(ok_oe || pull);
   always #12.5 clk = ~clk;
   fssp_top i_fssp_top (.clk(clk), .nrst(nrst), .bus(bus), .rdata_q(rdata_q), .evt(evt),
      .heat_warn(heat_warn), .power_good(power_good), .ok_i(ok_i), .ok_o(ok_o),
      .ok_oe(ok_oe), .hs_en_q(hs_en_q), .ls_en_q(ls_en_q), .ls_force_q(ls_force_q),
      .vout_cmd_q(vout_cmd_q), .irq_q(irq_q));
   fssp_pm_model i_fssp_pm_model (.clk(clk), .line(ok_i), .send(send), .send_len(send_len),
      .pull(pull), .rx_len(rx_len));
   // ***************************************
   // helpers
   // ***************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic end_of_test();
      if (err_count == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic do_reset();
      @(posedge clk) nrst <= 1'b0;
      evt <= '0;
      cyc(2);
      nrst <= 1'b1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk) bus <= '0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk) bus <= '0;
      #1 chk(what, exp, rdata_q);
   endtask
   // ***************************************
   // scenarios
   // ***************************************
   initial begin
      int j;
      int ev;
      logic [7:0] sv;
      logic [4:0] plen;
      do_reset();
      rd(fssp_pkg::ADDR_FLAGS, 8'h7F, "flags reset");
      rd(fssp_pkg::ADDR_SPREAD, 8'h3F, "spread reset");
      rd(fssp_pkg::ADDR_STYLE, 8'h35, "style reset");
      rd(8'hF0, 8'h00, "unmapped");
      wr(fssp_pkg::ADDR_FLAGS, 8'h00);
      rd(fssp_pkg::ADDR_FLAGS, 8'h40, "flags read-only bits");
      // one random event source for each style
      for (int k = 1; k <= 3; k++) begin
         seed = lfsr(seed);
         j = int'(seed[7:0]) % 3;
         ev = (j == 0) ? fssp_pkg::EVT_HEAT : (j == 1) ? fssp_pkg::EVT_LOW : fssp_pkg::EVT_HIGH;
         sv = 8'h35;
         sv[2 * j +: 2] = k[1:0];
         plen = (k == 1) ? fssp_pkg::PULSE_SEQ : fssp_pkg::PULSE_CRIT;
         if (k == 3) plen = fssp_pkg::PULSE_EMER;
         do_reset();
         wr(fssp_pkg::ADDR_STYLE, sv);
         wr(fssp_pkg::ADDR_RATE, 8'h00);
         wr(fssp_pkg::ADDR_IRQ_EN, 8'h01);
         #1 chk("irq idle", 8'h00, {7'h00, irq_q});
         @(posedge clk) evt <= fssp_pkg::fssp_evt_t'(6'h01 << ev);
         cyc(2);
         #1 chk("hs_en", {7'h00, k == 1}, {7'h00, hs_en_q});
         if (k != 3) chk("ls_en", {7'h00, k == 1}, {7'h00, ls_en_q});
         chk("ls_force", {7'h00, k == 3}, {7'h00, ls_force_q});
         chk("irq", 8'h01, {7'h00, irq_q});
         cyc(14);
         chk("pulse length", {3'h0, plen}, {3'h0, rx_len});
         wr(fssp_pkg::ADDR_FLAGS, 8'hFF);
         rd(fssp_pkg::ADDR_FLAGS, 8'h7F ^ (8'h01 << ev), "flags fault");
         wr(fssp_pkg::ADDR_IRQ_CLR, 8'h01);
         cyc(2);
         #1 chk("irq cleared", 8'h00, {7'h00, irq_q});
         cyc(300);
         if (k == 1) chk("ramp end", 8'h00, vout_cmd_q);
         chk("hs_en down", 8'h00, {7'h00, hs_en_q});
         rd(fssp_pkg::ADDR_IRQ_ST, (k == 1) ? 8'h04 : 8'h00, "irq status");
      end
      do_reset();
      wr(fssp_pkg::ADDR_SPREAD, 8'h00);
      @(posedge clk) evt <= fssp_pkg::fssp_evt_t'(6'h01 << fssp_pkg::EVT_HIGH);
      cyc(20);
      chk("line released", 8'h00, {7'h00, ok_oe});
      chk("hs_en local", 8'h00, {7'h00, hs_en_q});
      chk("ok_o", 8'h00, {7'h00, ok_o});
      rd(fssp_pkg::ADDR_CTRL, 8'h0F, "ctrl off");
      @(posedge clk) evt <= '0;
      wr(fssp_pkg::ADDR_CTRL, 8'h01);
      #1 chk("restart hs_en", 8'h01, {7'h00, hs_en_q});
      chk("restart ls_force", 8'h00, {7'h00, ls_force_q});
      rd(fssp_pkg::ADDR_CTRL, 8'h00, "ctrl run");
      do_reset();
      @(posedge clk) send <= 1'b1;
      send_len <= fssp_pkg::PULSE_EMER;
      @(posedge clk) send <= 1'b0;
      cyc(30);
      chk("remote ls_force", 8'h01, {7'h00, ls_force_q});
      chk("remote hs_en", 8'h00, {7'h00, hs_en_q});
      rd(fssp_pkg::ADDR_IRQ_ST, 8'h02, "irq remote");
      end_of_test();
   end
   // the run needs about 1100 cycles
   initial begin
      #200000;
      err_count++;
      end_of_test();
   end
endmodule
